/* File: verilog/dfe_cfg_regs.v */
/*
  Control register bank 0x00..0x03 of a dual converter front end, reached over
  a 3-wire serial port (chip select, serial clock, serial data).
  Assumes the host frames each access with csActiveN low: one instruction byte
  (bit 7 high = read, low five bits = address) then one data byte. Serial clock
  is far slower than clk_sys; data is sampled on its rising edge, and read
  data is driven after its falling edge.
*/
// How it works
// - Direction bit makes the data pin also drive read data when set.
// - Bit order bit selects LSB-first shifting of every byte when set.
// - Writing soft reset 1 then 0 resets the whole register map.
// - Power-down bit disables all circuitry except the serial control port.
// - Auto power-down enable bit, reset to zero, drives auto power-down.
// - PLL lock bit is read only and reports the lock input.
// - Interpolation field picks 1x, 2x, 4x or 8x; resets to 00.
// - A bit supplies MSB of the five-bit data clock delay.
// - Zero stuffing enable bit, reset to zero.
// - Format bit selects unsigned binary when set, two's complement when clear.
// - Single port bit puts both channels on the first data port.
// - Real mode bit gates Q clocks and disables both modulators.
// - Delay enable bit applies the programmable data clock delay.
// - Inverse sinc filter enabled when set, bypassed when clear.
// - Invert bit puts data clock opposite to internal sample clock.
// - Invert bit flips transmit enable pin polarity, also I/Q select.
// - Q-first bit makes Q precede I in interleaved input.
// - Four-bit filter modulation mode field, reset to 0000.
// - Sync reserved bit six is stored and read back; software sets it.
`timescale 1ns/100ps
`include "dfe_cfg_map.vh"

module dfe_cfg_regs
(
  input wire clk_sys,
  input wire rst,
  input wire clkEn,
  input wire csActiveN,
  input wire serialClk,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOe,
  input wire pllLocked,
  output reg powerDown,
  output reg autoPowerDownEn,
  output reg [1:0] interpFactor,
  output reg [3:0] filterModMode,
  output reg dataClockDelayMsb,
  output reg zeroStuffEn,
  output reg unsignedFormat,
  output reg singlePort,
  output reg realMode,
  output reg qClockGate,
  output reg modulatorEnable,
  output reg dataClockDelayEn,
  output reg invSincEn,
  output reg dataClockInvert,
  output reg txEnableInvert,
  output reg qFirst,
  output reg syncReserved
);

  // ----------------------------------------------------------------
  // Frame sequencer states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_INSTR = 2'b01;
  localparam ST_DATA = 2'b10;
  localparam ST_DONE = 2'b11;

  reg [7:0] regSerial;
  reg [7:0] regInterp;
  reg [7:0] regFormat;
  reg [7:0] regSync;
  reg [1:0] state;
  reg [3:0] bitCount;
  reg [7:0] shiftIn;
  reg [7:0] shiftOut;
  reg isRead;
  reg [4:0] accessAddr;
  reg softResetArmed;
  reg [7:0] next_shiftIn;
  reg [7:0] readByte;

  wire csLevel;
  wire sclkRise;
  wire sclkFall;
  wire sdiLevel;
  wire frameActive;
  wire lsbFirst;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dfe_pin_sync csSync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(~csActiveN), // Active high, so reset level means idle
    .level(csLevel),
    .rise(),
    .fall()
  );

  dfe_pin_sync sclkSync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(serialClk),
    .level(),
    .rise(sclkRise),
    .fall(sclkFall)
  );

  dfe_pin_sync sdiSync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(serialDataIn),
    .level(sdiLevel),
    .rise(),
    .fall()
  );

  assign frameActive = csLevel;
  assign lsbFirst = regSerial[`DFE_BIT_LSB_FIRST];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Reverse bit order of a byte
  function [7:0] flipByte;
    input [7:0] b;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        flipByte[i] = b[7 - i];
    end
  endfunction

  // Register read mux, undefined bits of 0x00 and unused addresses forced low
  function [7:0] readMux;
    input [4:0] addr;
    input [7:0] rs;
    input [7:0] ri;
    input [7:0] rf;
    input [7:0] ry;
    input lock;
    begin
      case (addr)
        `DFE_ADDR_SERIAL_POWER:
          readMux = (rs & `DFE_MASK_SERIAL_POWER) | {6'h00, lock, 1'b0};
        `DFE_ADDR_INTERP: readMux = ri;
        `DFE_ADDR_FORMAT: readMux = rf;
        `DFE_ADDR_SYNC: readMux = ry;
        default: readMux = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Incoming shift value
  // ----------------------------------------------------------------
  // Shift direction follows bit order setting
  always @*
  begin
    next_shiftIn = shiftIn;
    if (lsbFirst)
      next_shiftIn = {sdiLevel, shiftIn[7:1]};
    else
      next_shiftIn = {shiftIn[6:0], sdiLevel};
    readByte = readMux(next_shiftIn[4:0], regSerial, regInterp, regFormat, regSync, pllLocked);
  end

  // ----------------------------------------------------------------
  // Serial frame sequencer and register writes
  // ----------------------------------------------------------------
  // Bytes shift on rising serial clock, read data on falling
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      bitCount <= 4'h0;
      shiftIn <= 8'h00;
      shiftOut <= 8'h00;
      isRead <= 1'b0;
      accessAddr <= 5'h00;
      softResetArmed <= 1'b0;
      regSerial <= `DFE_RST_SERIAL_POWER;
      regInterp <= `DFE_RST_INTERP;
      regFormat <= `DFE_RST_FORMAT;
      regSync <= `DFE_RST_SYNC;
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!frameActive)
      begin
        state <= ST_IDLE;
        serialDataOe <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            bitCount <= 4'h0;
            state <= ST_INSTR;
          end
          ST_INSTR:
          begin
            if (sclkRise)
            begin
              shiftIn <= next_shiftIn;
              bitCount <= bitCount + 4'h1;
              if (bitCount == `DFE_BITS_PER_BYTE - 4'h1)
              begin
                isRead <= next_shiftIn[`DFE_INSTR_READ_BIT];
                accessAddr <= next_shiftIn[4:0];
                shiftOut <= lsbFirst ? flipByte(readByte) : readByte;
                bitCount <= 4'h0;
                state <= ST_DATA;
              end
            end
          end
          ST_DATA:
          begin
            // Shift read data out in either mode; enable the pin only in bidirectional mode
            if (sclkFall && isRead)
            begin
              serialDataOut <= shiftOut[7];
              shiftOut <= {shiftOut[6:0], 1'b0};
              serialDataOe <= regSerial[`DFE_BIT_BIDIR];
            end
            if (sclkRise)
            begin
              shiftIn <= next_shiftIn;
              bitCount <= bitCount + 4'h1;
              if (bitCount == `DFE_BITS_PER_BYTE - 4'h1)
              begin
                state <= ST_DONE;
                if (!isRead)
                begin
                  case (accessAddr)
                    `DFE_ADDR_SERIAL_POWER:
                    begin
                      // Lock bit and undefined bits ignore writes
                      regSerial <= next_shiftIn & `DFE_MASK_SERIAL_POWER;
                      if (next_shiftIn[`DFE_BIT_SOFT_RESET])
                        softResetArmed <= 1'b1;
                      else if (softResetArmed)
                      begin
                        // One then zero: reset the map
                        softResetArmed <= 1'b0;
                        regSerial <= `DFE_RST_SERIAL_POWER;
                        regInterp <= `DFE_RST_INTERP;
                        regFormat <= `DFE_RST_FORMAT;
                        regSync <= `DFE_RST_SYNC;
                      end
                    end
                    `DFE_ADDR_INTERP: regInterp <= next_shiftIn;
                    `DFE_ADDR_FORMAT: regFormat <= next_shiftIn;
                    `DFE_ADDR_SYNC: regSync <= next_shiftIn;
                    default: regSync <= regSync;
                  endcase
                end
              end
            end
          end
          ST_DONE:
          begin
            if (sclkFall)
              serialDataOe <= 1'b0;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs, registered from the bank
  // ----------------------------------------------------------------
  // Decoded controls for the datapath
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      powerDown <= 1'b0;
      autoPowerDownEn <= 1'b0;
      interpFactor <= 2'b00;
      filterModMode <= 4'h0;
      dataClockDelayMsb <= 1'b0;
      zeroStuffEn <= 1'b0;
      unsignedFormat <= 1'b0;
      singlePort <= 1'b0;
      realMode <= 1'b0;
      qClockGate <= 1'b0;
      modulatorEnable <= 1'b1;
      dataClockDelayEn <= 1'b0;
      invSincEn <= 1'b0;
      dataClockInvert <= 1'b0;
      txEnableInvert <= 1'b0;
      qFirst <= 1'b0;
      syncReserved <= 1'b0;
    end
    else if (clkEn)
    begin
      powerDown <= regSerial[`DFE_BIT_POWER_DOWN];
      autoPowerDownEn <= regSerial[`DFE_BIT_AUTO_PD];
      interpFactor <= regInterp[`DFE_FLD_INTERP_HI:`DFE_FLD_INTERP_LO];
      filterModMode <= regInterp[`DFE_FLD_FILTER_MODE_HI:`DFE_FLD_FILTER_MODE_LO];
      dataClockDelayMsb <= regInterp[`DFE_BIT_DCLK_DELAY_MSB];
      zeroStuffEn <= regInterp[`DFE_BIT_ZERO_STUFF];
      unsignedFormat <= regFormat[`DFE_BIT_UNSIGNED];
      singlePort <= regFormat[`DFE_BIT_SINGLE_PORT];
      realMode <= regFormat[`DFE_BIT_REAL_MODE];
      qClockGate <= regFormat[`DFE_BIT_REAL_MODE] | regSerial[`DFE_BIT_POWER_DOWN];
      modulatorEnable <= ~(regFormat[`DFE_BIT_REAL_MODE] | regSerial[`DFE_BIT_POWER_DOWN]);
      dataClockDelayEn <= regFormat[`DFE_BIT_DCLK_DELAY_EN];
      invSincEn <= regFormat[`DFE_BIT_INV_SINC];
      dataClockInvert <= regFormat[`DFE_BIT_DCLK_INVERT];
      txEnableInvert <= regFormat[`DFE_BIT_TXEN_INVERT];
      qFirst <= regFormat[`DFE_BIT_Q_FIRST];
      syncReserved <= regSync[`DFE_BIT_SYNC_RSVD];
    end
  end

endmodule

/* File: verilog/dfe_cfg_map.vh */
/*
  Register map of the converter front-end control bank: offsets, field positions,
  reset values and serial frame sizes.
  Assumes it is included by its bare name from design files only.
*/
`ifndef DFE_CFG_MAP_VH
`define DFE_CFG_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DFE_ADDR_SERIAL_POWER 5'h00
`define DFE_ADDR_INTERP 5'h01
`define DFE_ADDR_FORMAT 5'h02
`define DFE_ADDR_SYNC 5'h03

// ----------------------------------------------------------------
// Serial port and power control fields
// ----------------------------------------------------------------
`define DFE_BIT_BIDIR 7
`define DFE_BIT_LSB_FIRST 6
`define DFE_BIT_SOFT_RESET 5
`define DFE_BIT_POWER_DOWN 4
`define DFE_BIT_AUTO_PD 3
`define DFE_BIT_PLL_LOCK 1
`define DFE_MASK_SERIAL_POWER 8'hf8

// ----------------------------------------------------------------
// Interpolation control fields
// ----------------------------------------------------------------
`define DFE_FLD_INTERP_HI 7
`define DFE_FLD_INTERP_LO 6
`define DFE_FLD_FILTER_MODE_HI 5
`define DFE_FLD_FILTER_MODE_LO 2
`define DFE_BIT_DCLK_DELAY_MSB 1
`define DFE_BIT_ZERO_STUFF 0

// ----------------------------------------------------------------
// Input format control fields
// ----------------------------------------------------------------
`define DFE_BIT_UNSIGNED 7
`define DFE_BIT_SINGLE_PORT 6
`define DFE_BIT_REAL_MODE 5
`define DFE_BIT_DCLK_DELAY_EN 4
`define DFE_BIT_INV_SINC 3
`define DFE_BIT_DCLK_INVERT 2
`define DFE_BIT_TXEN_INVERT 1
`define DFE_BIT_Q_FIRST 0

// ----------------------------------------------------------------
// Sync control: reserved bit software must set
// ----------------------------------------------------------------
`define DFE_BIT_SYNC_RSVD 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DFE_RST_SERIAL_POWER 8'h00
`define DFE_RST_INTERP 8'h00
`define DFE_RST_FORMAT 8'h00
`define DFE_RST_SYNC 8'h00

// ----------------------------------------------------------------
// Serial frame: one instruction byte then one data byte
// ----------------------------------------------------------------
`define DFE_INSTR_READ_BIT 7
`define DFE_BITS_PER_BYTE 4'h8

`endif

/* File: verilog/dfe_pin_sync.v */
/*
  Three-stage pin synchroniser with agreement filter and edge pulses.
  Assumes the input is asynchronous to clk_sys; a change counts once the
  second and third stages agree.
*/
`timescale 1ns/100ps

module dfe_pin_sync
(
  input wire clk_sys,
  input wire rst,
  input wire clkEn,
  input wire pinIn,
  output reg level,
  output reg rise,
  output reg fall
);

  reg stage1;
  reg stage2;
  reg stage3;

  // ----------------------------------------------------------------
  // Synchroniser and filtered level
  // ----------------------------------------------------------------
  // Stage one feeds stage two only
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else if (clkEn)
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      rise <= 1'b0;
      fall <= 1'b0;
      if (stage2 == stage3 && stage3 != level)
      begin
        level <= stage3;
        rise <= stage3;
        fall <= ~stage3;
      end
    end
  end

endmodule

/* File: verification/dfe_cfg_regs_sva.sv */
/*
  Checker for the converter front-end control bank, bound to dfe_cfg_regs.
  Assumes it sees only the top ports, all in the clk_sys domain.
*/
`timescale 1ns/100ps

module dfe_cfg_regs_sva
(
  input wire clk_sys,
  input wire rst,
  input wire csActiveN,
  input wire serialClk,
  input wire serialDataOut,
  input wire serialDataOe,
  input wire powerDown,
  input wire autoPowerDownEn,
  input wire realMode,
  input wire qClockGate,
  input wire modulatorEnable,
  input wire [1:0] interpFactor,
  input wire [3:0] filterModMode,
  input wire zeroStuffEn,
  input wire invSincEn,
  input wire syncReserved
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_qgate_cause:
    assert property (qClockGate == (realMode || powerDown)) else $error("q gate wrong");
  a_modulator_off:
    assert property (modulatorEnable == !(realMode || powerDown)) else $error("modulator wrong");
  a_oe_cs_idle:
    assert property (csActiveN [*6] |-> !serialDataOe) else $error("pin driven while idle");
  a_oe_rise_low:
    assert property ($rose(serialDataOe) |-> !serialClk && !csActiveN) else $error("oe rise");
  a_oe_drop_bound:
    assert property ($rose(csActiveN) |-> ##[0:6] !serialDataOe) else $error("oe held");
  a_read_bit_hold:
    assert property (serialDataOe && serialClk && $past(serialClk) |-> $stable(serialDataOut))
      else $error("read bit moved");
  a_cfg_idle_hold:
    assert property (csActiveN && $past(csActiveN, 8) |-> $stable({powerDown, autoPowerDownEn,
      realMode, interpFactor, filterModMode, zeroStuffEn, invSincEn, syncReserved}))
      else $error("config moved while idle");
  a_reset_defaults:
    assert property (disable iff (1'b0) rst ##1 rst |=> interpFactor == 2'h0
      && filterModMode == 4'h0 && !zeroStuffEn && !autoPowerDownEn && !invSincEn
      && modulatorEnable && !serialDataOe) else $error("reset value wrong");

  // Main scenarios reached
  c_read_drive: cover property ($rose(serialDataOe));
  c_power_down: cover property ($rose(powerDown));
  c_real_mode: cover property ($rose(realMode));
endmodule

bind dfe_cfg_regs dfe_cfg_regs_sva chk (.clk_sys(clk_sys), .rst(rst), .csActiveN(csActiveN),
  .serialClk(serialClk), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
  .powerDown(powerDown), .autoPowerDownEn(autoPowerDownEn), .realMode(realMode),
  .qClockGate(qClockGate), .modulatorEnable(modulatorEnable), .interpFactor(interpFactor),
  .filterModMode(filterModMode), .zeroStuffEn(zeroStuffEn), .invSincEn(invSincEn),
  .syncReserved(syncReserved));

/* File: verification/dfe_host_model.sv */
/*
  Host model of the 3-wire serial port: instruction byte then data byte.
  Assumes the device clk_sys; pins change at its falling edge.
*/
`timescale 1ns/100ps

module dfe_host_model
(
  input wire clk_sys,
  input wire serialDataOut,
  input wire serialDataOe,
  output logic csActiveN,
  output logic serialClk,
  output wire serialDataIn
);
  // Serial half period in clk_sys cycles; the port needs at least 5
  localparam int HALF = 8;
  logic lsbFirst = 1'b0;
  // Set while the port runs bidirectional; else read data comes on the output line
  logic bidir = 1'b0;
  logic hostOe = 1'b0;
  logic hostBit = 1'b0;
  logic idleBit = 1'b0;
  logic oeSeen = 1'b0;

  // Wire level: device, else host, else a toggling released line
  assign serialDataIn = serialDataOe ? serialDataOut : (hostOe ? hostBit : idleBit);
  always @(negedge clk_sys) idleBit <= ~idleBit;
  initial
  begin
    csActiveN = 1'b1;
    serialClk = 1'b0;
  end

  // One byte, bit order as the host believes it
  task automatic shiftByte(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    int idx;
    for (int i = 0; i < 8; i++)
    begin
      idx = lsbFirst ? i : 7 - i;
      hostOe = drive;
      hostBit = tx[idx];
      repeat (HALF) @(negedge clk_sys);
      rx[idx] = bidir ? serialDataIn : serialDataOut;
      oeSeen = oeSeen | serialDataOe;
      serialClk = 1'b1;
      repeat (HALF) @(negedge clk_sys);
      serialClk = 1'b0;
    end
  endtask

  // Whole frame; the host releases the line for read data
  task automatic frame(input logic rd, input logic [4:0] addr, input logic [7:0] wd,
    output logic [7:0] rx);
    logic [7:0] junk;
    oeSeen = 1'b0;
    csActiveN = 1'b0;
    repeat (HALF) @(negedge clk_sys);
    shiftByte({rd, 2'b00, addr}, 1'b1, junk);
    shiftByte(wd, !rd, rx);
    repeat (HALF) @(negedge clk_sys);
    csActiveN = 1'b1;
    hostOe = 1'b0;
    repeat (4 * HALF) @(negedge clk_sys);
  endtask
endmodule

/* File: verification/dfe_cfg_regs_test.sv */
/*
  Self-checking bench for the control bank, through the serial host model.
  Assumes the checker is bound in; clkEn stays high except during one write frame sent with it low.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin failCount++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module dfe_cfg_regs_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic pllLocked = 1'b0;
  int failCount = 0;
  int numChecks = 0;
  wire csActiveN, serialClk, serialDataIn, serialDataOut, serialDataOe;
  wire powerDown, autoPowerDownEn, dataClockDelayMsb, zeroStuffEn, unsignedFormat;
  wire singlePort, realMode, qClockGate, modulatorEnable, dataClockDelayEn, invSincEn;
  wire dataClockInvert, txEnableInvert, qFirst, syncReserved;
  wire [1:0] interpFactor;
  wire [3:0] filterModMode;
  wire [7:0] interpOut = {interpFactor, filterModMode, dataClockDelayMsb, zeroStuffEn};
  wire [7:0] fmtOut = {unsignedFormat, singlePort, realMode, dataClockDelayEn, invSincEn,
    dataClockInvert, txEnableInvert, qFirst};

  logic [7:0] tbl [4] = '{8'h01, 8'h56, 8'hab, 8'hfe};

  always #25 clk_sys = ~clk_sys;

  dfe_host_model host (.clk_sys(clk_sys), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .csActiveN(csActiveN), .serialClk(serialClk),
    .serialDataIn(serialDataIn));
  dfe_cfg_regs uut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .csActiveN(csActiveN),
    .serialClk(serialClk), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .pllLocked(pllLocked), .powerDown(powerDown),
    .autoPowerDownEn(autoPowerDownEn), .interpFactor(interpFactor),
    .filterModMode(filterModMode), .dataClockDelayMsb(dataClockDelayMsb),
    .zeroStuffEn(zeroStuffEn), .unsignedFormat(unsignedFormat), .singlePort(singlePort),
    .realMode(realMode), .qClockGate(qClockGate), .modulatorEnable(modulatorEnable),
    .dataClockDelayEn(dataClockDelayEn), .invSincEn(invSincEn),
    .dataClockInvert(dataClockInvert), .txEnableInvert(txEnableInvert), .qFirst(qFirst),
    .syncReserved(syncReserved));

  // ----------------------------------------
  // Access tasks and closing
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] junk;
    host.frame(1'b0, a, d, junk);
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] got;
    host.frame(1'b1, a, 8'h00, got);
    `CHK(got, e)
  endtask

  task automatic endTest(input string name);
    $display("Test %s done, %0d mismatches so far", name, failCount);
  endtask

  task automatic results;
    $display("Checks made: %0d, mismatches: %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #3000000;
    failCount++;
    results;
  end

  // Main sequence
  initial
  begin
    logic [7:0] v;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK(interpOut, 8'h00)
    `CHK(fmtOut, 8'h00)
    `CHK({powerDown, autoPowerDownEn, qClockGate, modulatorEnable}, 4'h1)
    rdChk(5'h00, 8'h00);
    `CHK(host.oeSeen, 1'b0)
    endTest("reset");
    wr(5'h00, 8'h87);
    host.bidir = 1'b1;
    pllLocked = 1'b1;
    rdChk(5'h00, 8'h82);
    `CHK(host.oeSeen, 1'b1)
    pllLocked = 1'b0;
    rdChk(5'h00, 8'h80);
    endTest("status");
    foreach (tbl[i])
    begin
      wr(5'h01, tbl[i]);
      `CHK(interpOut, tbl[i])
      rdChk(5'h01, tbl[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      wr(5'h02, v);
      `CHK(fmtOut, v)
      `CHK({qClockGate, modulatorEnable}, {v[5], !v[5]})
      rdChk(5'h02, v);
    end
    wr(5'h03, 8'h40);
    `CHK(syncReserved, 1'b1)
    rdChk(5'h03, 8'h40);
    wr(5'h1a, 8'hff);
    rdChk(5'h1a, 8'h00);
    endTest("fields");
    wr(5'h00, 8'hc0);
    host.lsbFirst = 1'b1;
    rdChk(5'h01, 8'hfe);
    wr(5'h01, 8'h56);
    `CHK(interpOut, 8'h56)
    // Frozen block ignores a whole frame
    clkEn = 1'b0;
    wr(5'h01, 8'h33);
    clkEn = 1'b1;
    `CHK(interpOut, 8'h56)
    wr(5'h00, 8'hd0);
    `CHK({powerDown, qClockGate, modulatorEnable}, 3'b110)
    wr(5'h00, 8'hc8);
    `CHK({powerDown, autoPowerDownEn, modulatorEnable}, 3'b011)
    endTest("order and power");
    wr(5'h00, 8'he0);
    `CHK(interpOut, 8'h56)
    wr(5'h00, 8'h40);
    host.lsbFirst = 1'b0;
    host.bidir = 1'b0;
    `CHK({interpOut, fmtOut, syncReserved}, 17'h0)
    wr(5'h00, 8'h80);
    host.bidir = 1'b1;
    rdChk(5'h03, 8'h00);
    endTest("soft reset");
    results;
  end
endmodule
